// [core/exec_pkg.sv]
// constants for the swap / xor / tristate-load execute block
package exec_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int DEST_BIT = 7;
    localparam int TRISTATE_SEL_W = 3;
    // instruction field positions
    localparam int OPC_MSB = 13;
    localparam int OPC6_LSB = 8;
    localparam int OPC6_W = 6;
    localparam int OPC11_LSB = 3;
    localparam int OPC11_W = 11;
    localparam int NIB_W = 4;
    // opcode match fields
    localparam logic [5:0] SWAP_OPC = 6'h0e;   // 00 1110 dfff ffff
    localparam logic [5:0] XORLIT_OPC = 6'h3a; // 11 1010 kkkk kkkk
    localparam logic [5:0] XORF_OPC = 6'h06;   // 00 0110 dfff ffff
    localparam logic [10:0] TRISTATE_OPC = 11'h00c; // 00 0000 0110 0fff
    localparam logic [2:0] TRISTATE_MIN = 3'h5;
    localparam logic [2:0] TRISTATE_MAX = 3'h7;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] TRISTATE_RST = 8'hff;
    localparam int TRISTATE_N = 3;
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_SWAP = 3'b001,
        OP_XORL = 3'b010,
        OP_XORF = 3'b011,
        OP_TLOAD = 3'b100
    } op_e;
endpackage

// [core/nibble_swap_xor_tristate_exec.sv]
// decode and one-cycle execute: swap, xor literal, xor file, tristate load
// Contract
// RULE1: swap exchanges source register nibbles
// RULE2: swap destination bit selects accumulator/file; flags untouched
// RULE3: literal xor writes accumulator with accumulator xor literal
// RULE4: tristate load copies accumulator, operand 5..7
// RULE5: file xor writes destination, updates zero flag
// RULE6: file xor destination select; single cycle each
`default_nettype none
module nibble_swap_xor_tristate_exec
    import exec_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // instruction from fetch
    input wire logic insn_valid,
    input wire logic [INSN_W-1:0] insn,
    // register file read port (combinational, addressed by insn)
    output logic [FADDR_W-1:0] file_raddr,
    input wire logic [DATA_W-1:0] file_rdata,
    // register file write port
    output logic file_we,
    output logic [FADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    // zero flag update
    output logic zero_we,
    output logic zero_val,
    // core state
    output logic [DATA_W-1:0] acc,
    output logic [DATA_W-1:0] tristate_5,
    output logic [DATA_W-1:0] tristate_6,
    output logic [DATA_W-1:0] tristate_7,
    // decode status
    output logic op_known
);
    // instruction fields
    logic [OPC6_W-1:0] opc6;
    logic [OPC11_W-1:0] opc11;
    logic [TRISTATE_SEL_W-1:0] tsel;
    logic [DATA_W-1:0] literal;
    logic dest;
    logic tsel_in_range;

    // decoded operation and its result
    op_e op;
    logic [DATA_W-1:0] swap_val;
    logic [DATA_W-1:0] result;
    logic writes_file;
    logic writes_acc;

    // accumulator
    logic [DATA_W-1:0] acc_r, acc_nxt;

    // file write port
    logic file_we_r, file_we_nxt;
    logic [FADDR_W-1:0] file_waddr_r, file_waddr_nxt;
    logic [DATA_W-1:0] file_wdata_r, file_wdata_nxt;

    // zero flag
    logic zero_we_r, zero_we_nxt;
    logic zero_val_r, zero_val_nxt;

    // tristate control bank, index 0 is register 5
    logic [DATA_W-1:0] tristate_r [TRISTATE_N];
    logic [DATA_W-1:0] tristate_nxt [TRISTATE_N];

    // the file address field doubles as the read address
    assign opc6 = insn[OPC_MSB:OPC6_LSB];
    assign opc11 = insn[OPC_MSB:OPC11_LSB];
    assign tsel = insn[TRISTATE_SEL_W-1:0];
    assign literal = insn[DATA_W-1:0];
    assign dest = insn[DEST_BIT];
    assign file_raddr = insn[FADDR_W-1:0];

    // operands below 5 are refused so a stray word cannot hit a port
    assign tsel_in_range = (tsel >= TRISTATE_MIN) &&
                           (tsel <= TRISTATE_MAX);

    // priority order is harmless: the opcode fields never overlap
    always_comb begin
        op = OP_NONE;
        if (insn_valid) begin
            if (opc6 == SWAP_OPC) begin
                op = OP_SWAP;
            end else if (opc6 == XORLIT_OPC) begin
                op = OP_XORL;
            end else if (opc6 == XORF_OPC) begin
                op = OP_XORF;
            end else if (opc11 == TRISTATE_OPC && tsel_in_range) begin
                op = OP_TLOAD; // see RULE4
            end
        end
    end
    assign op_known = (op != OP_NONE);

    // swap reads the file even when it lands in the accumulator
    assign swap_val = {file_rdata[NIB_W-1:0],
                       file_rdata[DATA_W-1:NIB_W]}; // see RULE1

    always_comb begin
        result = '0;
        writes_file = 1'b0;
        writes_acc = 1'b0;
        case (op)
            OP_SWAP: begin
                result = swap_val;
                writes_file = dest; // see RULE2
                writes_acc = !dest;
            end
            OP_XORL: begin
                result = acc_r ^ literal; // see RULE3
                writes_acc = 1'b1;
            end
            OP_XORF: begin
                result = acc_r ^ file_rdata; // see RULE5
                writes_file = dest; // see RULE6
                writes_acc = !dest;
            end
            default: begin
                result = '0;
            end
        endcase
    end

    // accumulator: every op retires at the edge it is presented on
    always_comb begin
        acc_nxt = acc_r;
        if (writes_acc) begin
            acc_nxt = result; // see RULE6
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc_r <= ACC_RST;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // limitation: no forwarding here; a write followed by a read of the
    // same register relies on the register file to bypass its own write
    // address and data hold after the strobe; only file_we pulses
    always_comb begin
        file_we_nxt = 1'b0;
        file_waddr_nxt = file_waddr_r;
        file_wdata_nxt = file_wdata_r;
        if (writes_file) begin
            file_we_nxt = 1'b1;
            file_waddr_nxt = insn[FADDR_W-1:0];
            file_wdata_nxt = result;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            file_we_r <= 1'b0;
            file_waddr_r <= '0;
            file_wdata_r <= '0;
        end else begin
            file_we_r <= file_we_nxt;
            file_waddr_r <= file_waddr_nxt;
            file_wdata_r <= file_wdata_nxt;
        end
    end

    // only the file xor moves the flag; literal xor has no status to give
    always_comb begin
        zero_we_nxt = 1'b0;
        zero_val_nxt = zero_val_r;
        if (op == OP_XORF) begin
            zero_we_nxt = 1'b1;
            zero_val_nxt = (result == '0); // see RULE5
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            zero_we_r <= 1'b0;
            zero_val_r <= 1'b0;
        end else begin
            zero_we_r <= zero_we_nxt;
            zero_val_r <= zero_val_nxt;
        end
    end

    // one load strobe per register, picked by the operand offset
    for (genvar g = 0; g < TRISTATE_N; g++) begin : g_tristate
        logic hit;

        assign hit = (op == OP_TLOAD) &&
                     (tsel == TRISTATE_SEL_W'(TRISTATE_MIN + g));

        always_comb begin
            tristate_nxt[g] = tristate_r[g];
            if (hit) begin
                tristate_nxt[g] = acc_r; // see RULE4
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                tristate_r[g] <= TRISTATE_RST;
            end else begin
                tristate_r[g] <= tristate_nxt[g];
            end
        end
    end

    assign acc = acc_r;
    assign file_we = file_we_r;
    assign file_waddr = file_waddr_r;
    assign file_wdata = file_wdata_r;
    assign zero_we = zero_we_r;
    assign zero_val = zero_val_r;

    // bank entries brought out one port per register for the pin logic
    assign tristate_5 = tristate_r[0];
    assign tristate_6 = tristate_r[1];
    assign tristate_7 = tristate_r[2];
endmodule
`default_nettype wire

// [verif/exec_props.sv]
// port assertions for the swap / xor / tristate-load execute block
`default_nettype none
module exec_props import exec_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // instruction and register file
    input wire logic insn_valid,
    input wire logic [13:0] insn,
    input wire logic [6:0] file_raddr,
    input wire logic [7:0] file_rdata,
    input wire logic file_we,
    input wire logic [6:0] file_waddr,
    input wire logic [7:0] file_wdata,
    // flag and state
    input wire logic zero_we,
    input wire logic zero_val,
    input wire logic [7:0] acc,
    input wire logic [7:0] tristate_5,
    input wire logic [7:0] tristate_6,
    input wire logic [7:0] tristate_7,
    input wire logic op_known
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic sw = insn_valid && insn[13:8] == SWAP_OPC;
    wire logic xl = insn_valid && insn[13:8] == XORLIT_OPC;
    wire logic xf = insn_valid && insn[13:8] == XORF_OPC;
    wire logic tr = insn_valid && insn[13:3] == TRISTATE_OPC;
    chk_decode_known: assert property (sw || xl || xf ||
        (tr && insn[2:0] >= TRISTATE_MIN) |-> op_known)
        else $error("known opcode not flagged");
    chk_swap_acc: assert property (sw && !insn[7] |=>
        acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("swap to acc wrong");
    chk_swap_file: assert property (sw && insn[7] |=>
        file_we && !zero_we && $stable(acc))
        else $error("swap to file wrong");
    chk_xorl_acc: assert property (xl |=>
        acc == ($past(acc) ^ $past(insn[7:0])))
        else $error("literal xor wrong");
    chk_tristate_load: assert property (tr && insn[2:0] == 3'h6 |=>
        tristate_6 == $past(acc) && !zero_we)
        else $error("tristate load wrong");
    chk_tristate_refuse: assert property (tr &&
        insn[2:0] < TRISTATE_MIN |-> !op_known ##1 $stable(tristate_5))
        else $error("bad tristate operand taken");
    chk_xorf_zero: assert property (xf |=> zero_we &&
        zero_val == (($past(acc) ^ $past(file_rdata)) == 8'h00))
        else $error("file xor zero flag wrong");
    chk_xorf_dest: assert property (xf && !insn[7] |=>
        acc == ($past(acc) ^ $past(file_rdata)) && !file_we)
        else $error("file xor to acc wrong");
endmodule
`default_nettype wire

// [verif/nibble_swap_xor_tristate_exec_tb.sv]
// self-checking bench for the swap / xor / tristate-load execute block
`default_nettype none
module nibble_swap_xor_tristate_exec_tb import exec_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'h0, rst = 1'h1, insn_valid = 1'h0;
    logic file_we, zero_we, zero_val, op_known;
    logic [13:0] insn = 14'h0000;
    logic [6:0] file_raddr, file_waddr;
    logic [7:0] file_rdata = 8'h00, file_wdata, acc;
    logic [7:0] tristate_5, tristate_6, tristate_7;
    int errors = 0, comparisons = 0;
    nibble_swap_xor_tristate_exec DUT (.*);
    initial forever #10 mclk = ~mclk;
    task chk(string n, logic [7:0] s, logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask
    // one instruction, held for exactly one edge
    task op(logic [13:0] i, logic [7:0] r);
        @(posedge mclk);
        insn <= i;
        file_rdata <= r;
        insn_valid <= 1'h1;
        @(posedge mclk);
        insn_valid <= 1'h0;
        #1;
    endtask
    task t_xorl;
        chk("acc", acc, ACC_RST);
        chk("tristate_5", tristate_5, TRISTATE_RST);
        op(14'h3ab5, 8'h00);
        op(14'h3aaf, 8'h00);
        chk("acc", acc, 8'h1a);
    endtask
    task t_swap;
        op(14'h0e10, 8'ha5);
        chk("acc", acc, 8'h5a);
        chk("file_we", 8'(file_we), 8'h00);
        chk("zero_we", 8'(zero_we), 8'h00);
        chk("file_raddr", 8'(file_raddr), 8'h10);
        op(14'h0e90, 8'h3c);
        chk("file_we", 8'(file_we), 8'h01);
        chk("file_wdata", file_wdata, 8'hc3);
        chk("file_waddr", 8'(file_waddr), 8'h10);
        chk("acc", acc, 8'h5a);
    endtask
    task t_xorf;
        op(14'h3aef, 8'h00);
        op(14'h0690, 8'haf);
        chk("file_wdata", file_wdata, 8'h1a);
        chk("file_we", 8'(file_we), 8'h01);
        chk("zero_we", 8'(zero_we), 8'h01);
        chk("zero_val", 8'(zero_val), 8'h00);
        chk("acc", acc, 8'hb5);
        op(14'h0610, 8'hb5);
        chk("acc", acc, 8'h00);
        chk("zero_val", 8'(zero_val), 8'h01);
    endtask
    task t_tristate;
        op(14'h3a3c, 8'h00);
        op(14'h0064, 8'h00);
        chk("tristate_5", tristate_5, TRISTATE_RST);
        for (int s = 5; s < 8; s++) op(14'(14'h0060 + s), 8'h00);
        chk("tristate_5", tristate_5, 8'h3c);
        chk("tristate_6", tristate_6, 8'h3c);
        chk("tristate_7", tristate_7, 8'h3c);
    endtask
    task report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        t_xorl;
        t_swap;
        t_xorf;
        t_tristate;
        report_and_stop;
    end
    initial begin
        #100000;
        errors++;
        report_and_stop;
    end
endmodule
bind nibble_swap_xor_tristate_exec exec_props props (.*);
`default_nettype wire
